// ==== inc/pwr_mode_pkg.sv ====
/*
  Shared constants and types for the power-mode controller and its host end.
  Assumes one 25 MHz clock and a synchronous active-high reset at both ends.
*/
`default_nettype none
package pwr_mode_pkg;
  // ----------------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_POR      = 2'b00,
    MODE_SHUTDOWN = 2'b01,
    MODE_SLEEP    = 2'b10,
    MODE_ACTIVE   = 2'b11
  } power_mode_e;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ            = 25_000_000;
  localparam int unsigned WAKE_STARTUP_US   = 100;
  localparam int unsigned WAKE_STARTUP_CYC  = (WAKE_STARTUP_US * (CLK_HZ / 1_000_000));
  localparam int unsigned LINK_TIMEOUT_MS   = 1000;
  localparam int unsigned LINK_TIMEOUT_CYC  = LINK_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMER_W           = 32;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic RESET_FLAG_RST  = 1'b0;
  localparam logic SUPPLY_FLT_RST  = 1'b0;
endpackage
`default_nettype wire

// ==== inc/pwr_mode_if.sv ====
/*
  Signals between the power-mode controller and the host sequencer.
  Assumes both ends share i_clk; wake and resume pulses are one cycle.
*/
`timescale 1ns/1ns
`default_nettype none
interface pwr_mode_if;
  import pwr_mode_pkg::*;
  logic        wake_n;          // Wake pin, low pulse wakes
  logic        resume;          // Resume signal pulse
  logic        enter_sleep_cmd;
  logic        enter_powerdown_cmd;
  logic        reset_flag_clear_bit;
  logic        supply_fault_clear;
  logic        monitors_enable;
  logic        frame_valid;
  logic        reset_occurred_flag;
  logic        supply_fault;
  logic        fault_output_pin_n;
  power_mode_e mode;

  modport device (
    input  wake_n, resume, enter_sleep_cmd, enter_powerdown_cmd,
    input  reset_flag_clear_bit, supply_fault_clear, monitors_enable, frame_valid,
    output reset_occurred_flag, supply_fault, fault_output_pin_n, mode
  );
  modport host (
    output wake_n, resume, enter_sleep_cmd, enter_powerdown_cmd,
    output reset_flag_clear_bit, supply_fault_clear, monitors_enable, frame_valid,
    input  reset_occurred_flag, supply_fault, fault_output_pin_n, mode
  );
endinterface
`default_nettype wire

// ==== rtl/power_mode_controller.sv ====
/*
  Power-mode state machine of a stackable monitor: POR, shutdown, sleep, active.
  Assumes wake pin arrives asynchronously; chain tones are already decoded
  into one-cycle pulses by the daisy-chain receiver on i_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module power_mode_controller #(
  parameter int unsigned TIMEOUT_CYC = pwr_mode_pkg::LINK_TIMEOUT_CYC
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  pwr_mode_if.device                     bus,
  input  wire logic                      i_ref_ok,
  input  wire logic                      i_wake_tone,
  input  wire logic                      i_resume_tone,
  input  wire logic                      i_thermal_sd,
  input  wire logic                      i_timeout_en,
  input  wire logic                      i_supply_glitch,
  output logic                           o_settings_default,
  output logic                           o_wake_fwd,
  output logic                           o_resume_fwd,
  output logic                           o_drop_transactions,
  output logic                           o_sleep_monitors_on,
  output logic                           o_circuits_reset
);
  import pwr_mode_pkg::*;

  // Elaboration check: the counter must be able to reach the limit
  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 32'hFFFFFFFE) begin : g_bad_timeout
    $error("TIMEOUT_CYC out of range");
  end

  // ----------------------------------------------------------------------
  // Input synchronisers and event decode
  // ----------------------------------------------------------------------
  logic [1:0] wake_sync_r;
  logic [1:0] ref_sync_r;
  logic       wake_prev_r;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wake_sync_r <= 2'b11;
      ref_sync_r  <= 2'b00;
      wake_prev_r <= 1'b1;
    end else begin
      wake_sync_r <= {wake_sync_r[0], bus.wake_n};
      ref_sync_r  <= {ref_sync_r[0], i_ref_ok};
      wake_prev_r <= wake_sync_r[1];
    end
  end

  logic ref_ok;
  logic wake_ev;
  logic resume_ev;
  assign ref_ok    = ref_sync_r[1];
  // Low pulse on the pin acts on its release, like a tone acts on its end
  assign wake_ev   = (wake_sync_r[1] & ~wake_prev_r) | i_wake_tone;
  assign resume_ev = bus.resume | i_resume_tone;

  // ----------------------------------------------------------------------
  // Mode machine
  // ----------------------------------------------------------------------
  power_mode_e mode_r;
  power_mode_e mode_nxt;
  logic [TIMER_W-1:0] idle_cnt_r;
  logic               timed_out;
  assign timed_out = i_timeout_en && (idle_cnt_r >= TIMER_W'(TIMEOUT_CYC));

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_POR: begin
        if (ref_ok) mode_nxt = MODE_SHUTDOWN;
      end
      MODE_SHUTDOWN: begin
        if (wake_ev) mode_nxt = MODE_ACTIVE;
      end
      MODE_SLEEP: begin
        if (i_thermal_sd) mode_nxt = MODE_SHUTDOWN;
        else if (wake_ev || resume_ev) mode_nxt = MODE_ACTIVE;
      end
      MODE_ACTIVE: begin
        if (i_thermal_sd || bus.enter_powerdown_cmd) mode_nxt = MODE_SHUTDOWN;
        else if (timed_out) mode_nxt = MODE_SHUTDOWN;
        else if (wake_ev) mode_nxt = MODE_ACTIVE;
        else if (bus.enter_sleep_cmd) mode_nxt = MODE_SLEEP;
      end
      default: mode_nxt = MODE_POR;
    endcase
    if (!ref_ok) mode_nxt = MODE_POR;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) mode_r <= MODE_POR;
    else mode_r <= mode_nxt;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) o_circuits_reset <= 1'b1;
    else o_circuits_reset <= (mode_nxt == MODE_POR);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) bus.mode <= MODE_POR;
    else bus.mode <= mode_nxt;
  end

  // ----------------------------------------------------------------------
  // Link timeout counter, counts only in active
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst || mode_r != MODE_ACTIVE || bus.frame_valid) idle_cnt_r <= '0;
    else if (!timed_out) idle_cnt_r <= idle_cnt_r + TIMER_W'(1);
  end

  // ----------------------------------------------------------------------
  // Event outputs
  // ----------------------------------------------------------------------
  logic wake_restore;
  assign wake_restore = wake_ev && ref_ok && !i_thermal_sd &&
                        (mode_r == MODE_SHUTDOWN || mode_r == MODE_SLEEP ||
                         (mode_r == MODE_ACTIVE && !bus.enter_powerdown_cmd && !timed_out));

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_settings_default <= 1'b1;
      o_wake_fwd         <= 1'b0;
      o_resume_fwd       <= 1'b0;
    end else begin
      o_settings_default <= wake_restore || mode_nxt == MODE_POR;
      o_wake_fwd         <= wake_restore && mode_r == MODE_ACTIVE;
      // Resume changes no state in active, it is only passed on
      o_resume_fwd       <= resume_ev && !wake_ev && mode_r == MODE_ACTIVE &&
                            mode_nxt == MODE_ACTIVE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) o_drop_transactions <= 1'b0;
    else o_drop_transactions <= i_thermal_sd && mode_r != MODE_SHUTDOWN &&
                                mode_r != MODE_POR;
  end

  // ----------------------------------------------------------------------
  // Sleep monitors: latched only in active
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) o_sleep_monitors_on <= 1'b0;
    else if (mode_nxt == MODE_POR || mode_nxt == MODE_SHUTDOWN || wake_restore)
      o_sleep_monitors_on <= 1'b0;
    else if (mode_r == MODE_ACTIVE)
      o_sleep_monitors_on <= bus.monitors_enable;
  end

  // ----------------------------------------------------------------------
  // Reset flag and supply fault; set wins over clear
  // ----------------------------------------------------------------------
  logic reset_set;
  assign reset_set = (mode_r == MODE_POR && ref_ok) ||
                     (mode_r == MODE_SHUTDOWN && wake_ev) || wake_restore;

  always_ff @(posedge i_clk) begin
    if (i_rst) bus.reset_occurred_flag <= RESET_FLAG_RST;
    else if (reset_set) bus.reset_occurred_flag <= 1'b1;
    else if (bus.reset_flag_clear_bit) bus.reset_occurred_flag <= 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) bus.supply_fault <= SUPPLY_FLT_RST;
    else if (i_supply_glitch) bus.supply_fault <= 1'b1;
    else if (bus.supply_fault_clear) bus.supply_fault <= 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) bus.fault_output_pin_n <= 1'b1;
    else bus.fault_output_pin_n <= !(reset_set || bus.reset_occurred_flag ||
                                     i_supply_glitch || bus.supply_fault);
  end
endmodule
`default_nettype wire

// ==== rtl/power_mode_host.sv ====
/*
  Host end: drives wake, resume and commands, waits the startup time and
  clears the reset flag and supply fault after each wake request taken in idle.
  Assumes the device end shares i_clk and the interface carries the link.
*/
`timescale 1ns/1ns
`default_nettype none
module power_mode_host #(
  parameter int unsigned STARTUP_CYC = pwr_mode_pkg::WAKE_STARTUP_CYC
) (
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  pwr_mode_if.host    bus,
  input  wire logic   i_req_wake,
  input  wire logic   i_req_resume,
  input  wire logic   i_req_sleep,
  input  wire logic   i_req_shutdown,
  input  wire logic   i_monitors_want,
  input  wire logic   i_frame_seen,
  output logic        o_ready,
  output logic        o_busy
);
  import pwr_mode_pkg::*;

  // Elaboration check: a zero wait would underflow the compare below
  if (STARTUP_CYC < 1) begin : g_bad_startup
    $error("STARTUP_CYC must be at least 1");
  end

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_WAIT  = 2'b01,
    H_CLEAR = 2'b10
  } host_state_e;

  host_state_e        st_r;
  logic [TIMER_W-1:0] cnt_r;
  logic               wake_req;
  assign wake_req = i_req_wake && st_r == H_IDLE;

  // ----------------------------------------------------------------------
  // Sequencer: wake pulse, startup wait, flag clear
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r  <= H_IDLE;
      cnt_r <= '0;
    end else begin
      case (st_r)
        H_IDLE: begin
          cnt_r <= '0;
          if (i_req_wake) st_r <= H_WAIT;
        end
        H_WAIT: begin
          cnt_r <= cnt_r + TIMER_W'(1);
          if (cnt_r >= TIMER_W'(STARTUP_CYC - 1)) st_r <= H_CLEAR;
        end
        H_CLEAR: st_r <= H_IDLE;
        default: st_r <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bus.wake_n               <= 1'b1;
      bus.resume               <= 1'b0;
      bus.enter_sleep_cmd      <= 1'b0;
      bus.enter_powerdown_cmd  <= 1'b0;
      bus.reset_flag_clear_bit <= 1'b0;
      bus.supply_fault_clear   <= 1'b0;
      bus.monitors_enable      <= 1'b0;
      bus.frame_valid          <= 1'b0;
    end else begin
      bus.wake_n               <= !wake_req;
      bus.resume               <= i_req_resume && st_r == H_IDLE;
      // Commands only once startup is over
      bus.enter_sleep_cmd      <= i_req_sleep && st_r == H_IDLE &&
                                  bus.mode == MODE_ACTIVE;
      bus.enter_powerdown_cmd  <= i_req_shutdown && st_r == H_IDLE;
      bus.reset_flag_clear_bit <= st_r == H_CLEAR;
      bus.supply_fault_clear   <= st_r == H_CLEAR;
      // Monitor enables only change while the device is active
      if (bus.mode == MODE_ACTIVE) bus.monitors_enable <= i_monitors_want;
      bus.frame_valid          <= i_frame_seen && st_r == H_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ready <= 1'b0;
      o_busy  <= 1'b0;
    end else begin
      o_ready <= st_r == H_IDLE && bus.mode == MODE_ACTIVE;
      o_busy  <= st_r != H_IDLE;
    end
  end
endmodule
`default_nettype wire

// ==== verif/power_mode_controller_chk.sv ====
/*
  Concurrent checks on the power-mode link between the device and host ends.
  Assumes one shared clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module power_mode_controller_chk
  import pwr_mode_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        wake_n,
  input wire logic        resume,
  input wire logic        enter_sleep_cmd,
  input wire logic        enter_powerdown_cmd,
  input wire logic        reset_flag_clear_bit,
  input wire logic        supply_fault_clear,
  input wire logic        reset_occurred_flag,
  input wire logic        supply_fault,
  input wire logic        fault_output_pin_n,
  input wire power_mode_e mode
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // --------------------------------------------------------------------
  // Wake pin: one low cycle, acted on after the pin synchroniser
  // --------------------------------------------------------------------
  sequence wake_pulse;
    !wake_n ##1 wake_n;
  endsequence

  wake_enters_a: assert property ((mode inside {MODE_SHUTDOWN, MODE_SLEEP}) ##0 wake_pulse
    |-> ##[1:6] mode == MODE_ACTIVE) else $error("wake did not reach active");
  wake_flag_a: assert property ((mode inside {MODE_SHUTDOWN, MODE_ACTIVE}) ##0 wake_pulse
    |-> ##[1:6] reset_occurred_flag) else $error("wake did not set reset flag");

  // --------------------------------------------------------------------
  // Commands and resume
  // --------------------------------------------------------------------
  sleep_cmd_a: assert property (mode == MODE_ACTIVE && enter_sleep_cmd && !enter_powerdown_cmd
    |=> mode != MODE_ACTIVE) else $error("sleep command ignored");
  powerdown_cmd_a: assert property (mode == MODE_ACTIVE && enter_powerdown_cmd
    |=> mode inside {MODE_SHUTDOWN, MODE_POR}) else $error("powerdown command ignored");
  resume_sleep_a: assert property (mode == MODE_SLEEP && resume && wake_n
    |=> mode == MODE_ACTIVE) else $error("resume left sleep unchanged");
  resume_active_a: assert property (mode == MODE_ACTIVE && resume && wake_n && !enter_sleep_cmd
    && !enter_powerdown_cmd |=> mode == MODE_ACTIVE) else $error("resume changed active mode");

  // --------------------------------------------------------------------
  // Flags; set wins over a clear in the same cycle, so the reset flag clear is tested alone
  // --------------------------------------------------------------------
  flag_hold_a: assert property (reset_occurred_flag && !reset_flag_clear_bit
    |=> reset_occurred_flag) else $error("reset flag lost without clear");
  flag_clear_a: assert property (reset_flag_clear_bit && mode == MODE_ACTIVE && $stable(mode)
    && wake_n |=> !reset_occurred_flag) else $error("reset flag clear ignored");
  supply_clear_a: assert property (supply_fault && supply_fault_clear
    |=> !supply_fault) else $error("supply fault clear ignored");
  fault_release_a: assert property (!reset_occurred_flag && !supply_fault [*2]
    |-> fault_output_pin_n) else $error("fault pin held with no fault");
endmodule
`default_nettype wire

// ==== verif/power_mode_controller_bench.sv ====
/*
  Self-checking bench: device and host ends joined by one link interface.
  Assumes the design modules and package compile ahead of this file.
*/
`timescale 1ns/1ns
`default_nettype none
module power_mode_controller_bench;
  import pwr_mode_pkg::*;
  // Short counts keep the run brief; expectations follow from these
  localparam int STARTUP = 8;
  localparam int TIMEOUT = 20;
  typedef struct packed {logic [2:0] ev; power_mode_e mode; logic [3:0] pls; logic [3:0] msk;} row_s;
  logic       i_clk, i_rst, ref_ok, wake_tone, resume_tone, thermal, timeout_en, glitch;
  logic       req_wake, req_resume, req_sleep, req_shutdown, monitors_want, frame_seen;
  logic       settings_default, wake_fwd, resume_fwd, drop, monitors_on, circuits_reset;
  logic       clr_seen;
  logic       ready, busy;
  logic [3:0] seen;
  int         fails, cmp_count, cyc;
  // Events: 0 wake, 1 resume, 2 sleep, 3 shutdown, 4 wake tone, 5 resume tone, 6 thermal, 7 timeout
  // Pulses seen: default restore, wake forward, resume forward, drop
  row_s rows [19] = '{
    '{3'd0, MODE_ACTIVE, 4'h0, 4'h0}, '{3'd1, MODE_ACTIVE, 4'h2, 4'hE},
    '{3'd2, MODE_SLEEP, 4'h0, 4'h0}, '{3'd1, MODE_ACTIVE, 4'h0, 4'h8},
    '{3'd2, MODE_SLEEP, 4'h0, 4'h0}, '{3'd5, MODE_ACTIVE, 4'h0, 4'h8},
    '{3'd4, MODE_ACTIVE, 4'hC, 4'hC}, '{3'd2, MODE_SLEEP, 4'h0, 4'h0},
    '{3'd0, MODE_ACTIVE, 4'h8, 4'h8}, '{3'd3, MODE_SHUTDOWN, 4'h0, 4'h0},
    '{3'd4, MODE_ACTIVE, 4'h0, 4'h0}, '{3'd6, MODE_SHUTDOWN, 4'h1, 4'h1},
    '{3'd5, MODE_SHUTDOWN, 4'h0, 4'h0}, '{3'd2, MODE_SHUTDOWN, 4'h0, 4'h0},
    '{3'd0, MODE_ACTIVE, 4'h0, 4'h0}, '{3'd7, MODE_SHUTDOWN, 4'h0, 4'h0},
    '{3'd0, MODE_ACTIVE, 4'h8, 4'h8}, '{3'd2, MODE_SLEEP, 4'h0, 4'h0},
    '{3'd6, MODE_SHUTDOWN, 4'h1, 4'hF}};

  pwr_mode_if link ();
  power_mode_controller #(.TIMEOUT_CYC(TIMEOUT)) u_power_mode_controller (
    .i_clk(i_clk), .i_rst(i_rst), .bus(link), .i_ref_ok(ref_ok), .i_wake_tone(wake_tone),
    .i_resume_tone(resume_tone), .i_thermal_sd(thermal), .i_timeout_en(timeout_en),
    .i_supply_glitch(glitch), .o_settings_default(settings_default), .o_wake_fwd(wake_fwd),
    .o_resume_fwd(resume_fwd), .o_drop_transactions(drop), .o_sleep_monitors_on(monitors_on),
    .o_circuits_reset(circuits_reset));
  power_mode_host #(.STARTUP_CYC(STARTUP)) u_power_mode_host (
    .i_clk(i_clk), .i_rst(i_rst), .bus(link), .i_req_wake(req_wake), .i_req_resume(req_resume),
    .i_req_sleep(req_sleep), .i_req_shutdown(req_shutdown), .i_monitors_want(monitors_want),
    .i_frame_seen(frame_seen), .o_ready(ready), .o_busy(busy));
  power_mode_controller_chk u_power_mode_controller_chk (
    .i_clk(i_clk), .i_rst(i_rst), .wake_n(link.wake_n), .resume(link.resume),
    .enter_sleep_cmd(link.enter_sleep_cmd), .enter_powerdown_cmd(link.enter_powerdown_cmd),
    .reset_flag_clear_bit(link.reset_flag_clear_bit), .supply_fault_clear(link.supply_fault_clear),
    .reset_occurred_flag(link.reset_occurred_flag), .supply_fault(link.supply_fault),
    .fault_output_pin_n(link.fault_output_pin_n), .mode(link.mode));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Short pulses are caught here so a row can judge them after it settles
  always_ff @(posedge i_clk) begin
    if (clr_seen) seen <= 4'h0;
    else seen <= seen | {settings_default, wake_fwd, resume_fwd, drop};
  end

  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One event, then 40 cycles: covers wake sync, startup wait, clears and timeout
  task automatic fire(input logic [2:0] ev);
    @(negedge i_clk);
    clr_seen = 1'b1;
    @(negedge i_clk);
    clr_seen = 1'b0;
    case (ev)
      3'd0: req_wake = 1'b1;
      3'd1: req_resume = 1'b1;
      3'd2: req_sleep = 1'b1;
      3'd3: req_shutdown = 1'b1;
      3'd4: wake_tone = 1'b1;
      3'd5: resume_tone = 1'b1;
      3'd6: thermal = 1'b1;
      default: timeout_en = 1'b1;
    endcase
    @(negedge i_clk);
    {req_wake, req_resume, req_sleep, req_shutdown, wake_tone, resume_tone, thermal} = '0;
    repeat (40) @(negedge i_clk);
    timeout_en = 1'b0;
  endtask

  initial begin
    cyc = 0;
    forever begin
      @(posedge i_clk);
      cyc++;
      if (cyc == 3000) begin
        fails++;
        give_verdict();
      end
    end
  end

  initial begin
    {i_rst, ref_ok} = 2'b11;
    {wake_tone, resume_tone, thermal, timeout_en, glitch, clr_seen} = '0;
    {req_wake, req_resume, req_sleep, req_shutdown, monitors_want, frame_seen} = '0;
    fails = 0;
    cmp_count = 0;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (10) @(negedge i_clk);
    // ------------------------------------------------------------------
    // Table of ordinary transitions
    // ------------------------------------------------------------------
    foreach (rows[i]) begin
      fire(rows[i].ev);
      check({2'h0, link.mode}, {2'h0, rows[i].mode});
      check(seen & rows[i].msk, rows[i].pls & rows[i].msk);
      $display("row %0d done", i);
    end
    // ------------------------------------------------------------------
    // Sleep monitors latched in active only
    // ------------------------------------------------------------------
    monitors_want = 1'b1;
    fire(3'd0);
    fire(3'd2);
    check({3'h0, monitors_on}, 4'h1);
    monitors_want = 1'b0;
    repeat (5) @(negedge i_clk);
    check({3'h0, monitors_on}, 4'h1);
    fire(3'd1);
    fire(3'd2);
    check({3'h0, monitors_on}, 4'h0);
    $display("monitor test done");
    // ------------------------------------------------------------------
    // Supply fault and reset flag cleared by the host after a wake
    // ------------------------------------------------------------------
    fire(3'd1);
    glitch = 1'b1;
    @(negedge i_clk);
    glitch = 1'b0;
    @(negedge i_clk);
    check({3'h0, link.supply_fault}, 4'h1);
    fire(3'd0);
    check({1'h0, link.supply_fault, link.reset_occurred_flag, link.fault_output_pin_n}, 4'h1);
    $display("fault clear test done");
    // ------------------------------------------------------------------
    // Link timeout: frames hold it off, expiry counts from the last frame
    // ------------------------------------------------------------------
    frame_seen = 1'b1;
    repeat (2) @(negedge i_clk);
    timeout_en = 1'b1;
    repeat (TIMEOUT + 10) @(negedge i_clk);
    check({2'h0, link.mode}, {2'h0, MODE_ACTIVE});
    frame_seen = 1'b0;
    repeat (TIMEOUT + 1) @(negedge i_clk);
    check({2'h0, link.mode}, {2'h0, MODE_ACTIVE});
    @(negedge i_clk);
    check({2'h0, link.mode}, {2'h0, MODE_SHUTDOWN});
    timeout_en = 1'b0;
    $display("timeout test done");
    // ------------------------------------------------------------------
    // Host stays busy through the startup wait after a wake
    // ------------------------------------------------------------------
    req_wake = 1'b1;
    @(negedge i_clk);
    req_wake = 1'b0;
    repeat (6) @(negedge i_clk);
    check({ready, busy, link.mode}, {2'b01, MODE_ACTIVE});
    repeat (STARTUP) @(negedge i_clk);
    check({ready, busy, link.mode}, {2'b10, MODE_ACTIVE});
    $display("startup wait test done");
    // ------------------------------------------------------------------
    // Reference loss, mid-run reset, recovery
    // ------------------------------------------------------------------
    ref_ok = 1'b0;
    repeat (6) @(negedge i_clk);
    check({1'h0, circuits_reset, link.mode}, {2'h1, MODE_POR});
    i_rst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (10) @(negedge i_clk);
    check({settings_default, circuits_reset, link.mode}, {2'h3, MODE_POR});
    ref_ok = 1'b1;
    repeat (10) @(negedge i_clk);
    check({1'h0, link.reset_occurred_flag, link.mode}, {2'h1, MODE_SHUTDOWN});
    $display("reference test done");
    give_verdict();
  end
endmodule
`default_nettype wire
